// *** hw/reader_fifo_params.svh ***
// constants for the reader byte buffer block
`ifndef READER_FIFO_PARAMS_SVH
`define READER_FIFO_PARAMS_SVH
`define ADDR_W 7
`define DATA_W 8
`define CNT_W 10
`define IDX_W 9
`define MEM_DEPTH 512
`define DEPTH_SMALL 10'h0ff
`define DEPTH_LARGE 10'h200
`define CNT_ONE 10'h001
`define CNT_ZERO 10'h000
`define IDX_ZERO 9'h000
`define IDX_ONE 9'h001
`define ADDR_STEP 7'h01
`define REG_CTRL 7'h02
`define REG_WM 7'h03
`define REG_CNT 7'h04
`define REG_DATA 7'h05
`define CTRL_SIZE 7
`define CTRL_HI 6
`define CTRL_LO 5
`define CTRL_FLUSH 4
`define CTRL_WM8 2
`define CTRL_CNT_HI 1
`define CTRL_CNT_LO 0
`define RST_SIZE 1'b0
`define RST_WM8 1'b0
`define RST_WM 8'h00
`define RST_ADDR 7'h00
`define RST_BYTE 8'h00
`define STAGE_DEPTH 8
`endif

// *** hw/reader_fifo_pkg.sv ***
// types shared by the reader byte buffer block
`include "reader_fifo_params.svh"
package reader_fifo_pkg;
  typedef struct packed {
    logic access;
    logic write;
    logic addr_load;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } host_req_s;
  typedef struct packed {
    logic valid;
    logic [`DATA_W-1:0] data;
  } host_rsp_s;
endpackage

// *** hw/reader_fifo_buffer_control.sv ***
// byte buffer with watermark alerts, flush and a non-incrementing data port
// How it works
// RULE1: depth select one gives 255 bytes, zero gives 512 bytes.
// RULE2: host should change depth select only when the buffer is empty.
// RULE3: high alert when configured depth minus fill count is at most the watermark.
// RULE4: low alert when fill count is at most the watermark.
// RULE5: writing one to flush empties buffer, clears count; flush reads zero.
// RULE6: control bit 2 is watermark bit 8, used only in 512-byte depth.
// RULE7: control bits 1:0 read fill count bits 9:8, meaningful in 512 mode.
// RULE8: fill count register shows low eight count bits, read-only, resets zero.
// RULE9: data port write pushes and counts up; read pops and counts down.
// RULE10: data port accesses keep the address pointer; other addresses auto-increment.
// RULE11: watermark register at 03h holds low eight watermark bits, read/write.
// RULE12: writes when full are dropped; reads when empty return zero.
`timescale 1ns/10ps
`include "reader_fifo_params.svh"

module stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= '0;
      in_ready_out <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      // registered so the ready seen outside never has a combinational path
      in_ready_out <= (nxt_cnt != FULL_CNT);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end
endmodule

module reader_fifo_buffer_control
  import reader_fifo_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire host_req_s host_req_in,
  output host_rsp_s host_rsp_out,
  output logic [`ADDR_W-1:0] host_addr_out,
  input wire logic core_wvalid_in,
  input wire logic [`DATA_W-1:0] core_wdata_in,
  output logic core_wready_out,
  input wire logic core_pop_in,
  output logic core_rvalid_out,
  output logic [`DATA_W-1:0] core_rdata_out,
  output logic depth_select_out,
  output logic high_alert_flag_out,
  output logic low_alert_flag_out,
  output logic [`CNT_W-1:0] fill_count_out
);
  logic [`DATA_W-1:0] mem_ff [`MEM_DEPTH];
  logic [`IDX_W-1:0] wr_ptr_ff;
  logic [`IDX_W-1:0] rd_ptr_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic [`CNT_W-1:0] nxt_cnt;
  logic depth_sel_ff;
  logic wm8_ff;
  logic [`DATA_W-1:0] wm_lo_ff;
  logic [`ADDR_W-1:0] addr_ff;

  logic [`ADDR_W-1:0] eff_addr;
  logic host_wr;
  logic host_rd;
  logic sel_data;
  logic flush;
  logic [`CNT_W-1:0] cap;
  logic [`IDX_W-1:0] last_idx;
  logic full;
  logic empty;
  logic do_hpush;
  logic do_hpop;
  logic stage_valid;
  logic stage_ready;
  logic [`DATA_W-1:0] stage_data;
  logic stage_take;
  logic core_take;
  logic push;
  logic pop;
  logic [`DATA_W-1:0] push_data;
  logic [`IDX_W-1:0] wm_full;
  logic [`CNT_W-1:0] room;
  logic high_alert;
  logic low_alert;
  logic [`DATA_W-1:0] rdata;

  // transceiver-side bytes wait here while the host owns the write slot
  stage_fifo #(
    .WIDTH(`DATA_W),
    .DEPTH(`STAGE_DEPTH)
  ) u_stage (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(core_wvalid_in),
    .in_data_in(core_wdata_in),
    .in_ready_out(core_wready_out),
    .out_valid_out(stage_valid),
    .out_data_out(stage_data),
    .out_ready_in(stage_ready)
  );

  // an address load in the same cycle as an access steers that access
  assign eff_addr = host_req_in.addr_load ? host_req_in.addr : addr_ff;
  assign host_wr = host_req_in.access & host_req_in.write;
  assign host_rd = host_req_in.access & ~host_req_in.write;
  assign sel_data = (eff_addr == `REG_DATA);
  assign flush = host_wr & (eff_addr == `REG_CTRL) & host_req_in.wdata[`CTRL_FLUSH]; // RULE5

  assign cap = depth_sel_ff ? `DEPTH_SMALL : `DEPTH_LARGE; // RULE1
  assign last_idx = `IDX_W'(cap - `CNT_ONE);
  // >= rather than == keeps a shrink with content from overfilling
  assign full = (cnt_ff >= cap);
  assign empty = (cnt_ff == `CNT_ZERO);

  // host has priority over the transceiver side for both slots
  assign do_hpush = host_wr & sel_data & ~full; // RULE12
  // nothing leaves staging in a flush cycle, so the cleared buffer starts empty
  assign stage_ready = ~(host_wr & sel_data) & ~full & ~flush;
  assign stage_take = stage_valid & stage_ready;
  assign push = do_hpush | stage_take;
  assign push_data = do_hpush ? host_req_in.wdata : stage_data;
  assign do_hpop = host_rd & sel_data & ~empty & ~flush; // RULE12
  assign core_take = core_pop_in & ~(host_rd & sel_data) & ~empty & ~flush;
  assign pop = do_hpop | core_take;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (flush) begin
      nxt_cnt = `CNT_ZERO; // RULE5
    end else if (push && !pop) begin
      nxt_cnt = cnt_ff + `CNT_ONE; // RULE9
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - `CNT_ONE; // RULE9
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= `CNT_ZERO; // RULE8
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // pointers wrap at the selected depth, so a depth change with content
  // scrambles order; software is expected to empty first
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_ff <= `IDX_ZERO;
    end else if (flush) begin
      wr_ptr_ff <= `IDX_ZERO; // RULE5
    end else if (push) begin
      wr_ptr_ff <= (wr_ptr_ff >= last_idx) ? `IDX_ZERO : wr_ptr_ff + `IDX_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_ptr_ff <= `IDX_ZERO;
    end else if (flush) begin
      rd_ptr_ff <= `IDX_ZERO; // RULE5
    end else if (pop) begin
      rd_ptr_ff <= (rd_ptr_ff >= last_idx) ? `IDX_ZERO : rd_ptr_ff + `IDX_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= push_data; // RULE9
    end
  end

  // configuration registers; a flush write stores depth and bit 8 as well
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      depth_sel_ff <= `RST_SIZE;
    end else if (host_wr && eff_addr == `REG_CTRL) begin
      depth_sel_ff <= host_req_in.wdata[`CTRL_SIZE]; // RULE1
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wm8_ff <= `RST_WM8;
    end else if (host_wr && eff_addr == `REG_CTRL) begin
      wm8_ff <= host_req_in.wdata[`CTRL_WM8]; // RULE6
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wm_lo_ff <= `RST_WM;
    end else if (host_wr && eff_addr == `REG_WM) begin
      wm_lo_ff <= host_req_in.wdata; // RULE11
    end
  end

  // watermark bit 8 is ignored in the 255-byte depth
  assign wm_full = depth_sel_ff ? {1'b0, wm_lo_ff} : {wm8_ff, wm_lo_ff}; // RULE6
  // room clamps at zero so a count left over from a shrink cannot wrap
  assign room = full ? `CNT_ZERO : cap - cnt_ff;
  assign high_alert = (room <= {1'b0, wm_full}); // RULE3
  assign low_alert = (cnt_ff <= {1'b0, wm_full}); // RULE4

  always_comb begin
    rdata = `RST_BYTE;
    unique case (eff_addr)
      `REG_CTRL: begin
        rdata[`CTRL_SIZE] = depth_sel_ff;
        rdata[`CTRL_HI] = high_alert;
        rdata[`CTRL_LO] = low_alert;
        // flush and bit 3 are never stored, so they read zero
        rdata[`CTRL_WM8] = wm8_ff;
        rdata[`CTRL_CNT_HI] = cnt_ff[`CNT_W-1]; // RULE7
        rdata[`CTRL_CNT_LO] = cnt_ff[`CNT_W-2]; // RULE7
      end
      `REG_WM: begin
        rdata = wm_lo_ff; // RULE11
      end
      `REG_CNT: begin
        rdata = cnt_ff[`DATA_W-1:0]; // RULE8
      end
      `REG_DATA: begin
        rdata = empty ? `RST_BYTE : mem_ff[rd_ptr_ff]; // RULE12
      end
      default: begin
        rdata = `RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      host_rsp_out <= '0;
    end else begin
      host_rsp_out.valid <= host_rd;
      host_rsp_out.data <= host_rd ? rdata : `RST_BYTE;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_ff <= `RST_ADDR;
    end else if (host_req_in.access) begin
      addr_ff <= sel_data ? eff_addr : eff_addr + `ADDR_STEP; // RULE10
    end else if (host_req_in.addr_load) begin
      addr_ff <= host_req_in.addr;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_rvalid_out <= 1'b0;
    end else begin
      core_rvalid_out <= core_take; // RULE9
    end
  end

  // the byte stays after the pulse so a slow consumer may pick it up late
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_rdata_out <= `RST_BYTE;
    end else if (core_take) begin
      core_rdata_out <= mem_ff[rd_ptr_ff];
    end
  end

  // alert flag mirrors lag the internal state by one cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      high_alert_flag_out <= 1'b0;
    end else begin
      high_alert_flag_out <= high_alert; // RULE3
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_alert_flag_out <= 1'b0;
    end else begin
      low_alert_flag_out <= low_alert; // RULE4
    end
  end

  assign host_addr_out = addr_ff;
  assign fill_count_out = cnt_ff;
  assign depth_select_out = depth_sel_ff;
endmodule

// *** sim/reader_fifo_buffer_control_properties.sv ***
// port assertions for the reader byte buffer
`timescale 1ns/10ps
`include "reader_fifo_params.svh"
module reader_fifo_checker
  import reader_fifo_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire host_req_s host_req_in,
  input wire host_rsp_s host_rsp_out,
  input wire logic [`ADDR_W-1:0] host_addr_out,
  input wire logic core_pop_in,
  input wire logic core_rvalid_out,
  input wire logic depth_select_out,
  input wire logic high_alert_flag_out,
  input wire logic low_alert_flag_out,
  input wire logic [`CNT_W-1:0] fill_count_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire ld = host_req_in.access && host_req_in.addr_load;
  wire rd = host_req_in.access && !host_req_in.write;
  wire at_ctrl = host_req_in.addr == `REG_CTRL;
  wire at_data = host_req_in.addr == `REG_DATA;
  a_rsp_pulse: assert property (host_rsp_out.valid == $past(rd))
    else $error("read answer pulse wrong");
  a_flush_clear: assert property (ld && host_req_in.write && at_ctrl
    && host_req_in.wdata[`CTRL_FLUSH] |=> fill_count_out == `CNT_ZERO)
    else $error("flush left bytes");
  a_data_hold: assert property (ld && at_data |=> host_addr_out == `REG_DATA)
    else $error("data port moved pointer");
  a_addr_step: assert property (ld && !at_data |=>
    host_addr_out == $past(host_req_in.addr) + `ADDR_STEP)
    else $error("pointer did not step");
  a_low_empty: assert property (fill_count_out == `CNT_ZERO |=> low_alert_flag_out)
    else $error("low alert missing when empty");
  a_high_full: assert property (depth_select_out && fill_count_out == `DEPTH_SMALL
    |=> high_alert_flag_out)
    else $error("high alert missing when full");
  a_count_max: assert property (fill_count_out <= `DEPTH_LARGE)
    else $error("count beyond capacity");
  a_empty_read: assert property (rd && ld && at_data && fill_count_out == `CNT_ZERO
    |=> host_rsp_out.data == `RST_BYTE && fill_count_out == `CNT_ZERO)
    else $error("empty read not zero");
  a_core_pop: assert property (core_pop_in && !host_req_in.access
    && fill_count_out != `CNT_ZERO |=> core_rvalid_out)
    else $error("core pop not answered");
  cover property (ld && host_req_in.write && at_ctrl && host_req_in.wdata[`CTRL_FLUSH]);
  cover property (depth_select_out && fill_count_out == `DEPTH_SMALL);
  a_burst_hold: assert property (host_req_in.access && !host_req_in.addr_load
    && host_addr_out == `REG_DATA |=> host_addr_out == `REG_DATA)
    else $error("burst left data port");
  cover property (core_rvalid_out);
  cover property (host_req_in.access && !host_req_in.addr_load);
endmodule

// *** sim/host_model.sv ***
// host controller model making single register accesses
`timescale 1ns/10ps
module host_model
  import reader_fifo_pkg::*;
(
  input wire logic clk_in,
  output host_req_s req_out,
  input wire host_rsp_s rsp_in
);
  initial req_out = '0;
  // wr and rd load their address with the access, so a stale pointer cannot pick the target
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b1, 1'b1, a, d};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
  // access at the current pointer without loading it, as a burst goes on
  task automatic cont(input logic w, input logic [7:0] dw,
      output logic v, output logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, w, 1'b0, 7'h00, dw};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, 1'b0, 7'h7f, ~dw};
    @(posedge clk_in);
    v = rsp_in.valid;
    d = rsp_in.data;
  endtask
  task automatic rd(input logic [6:0] a, output logic v, output logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, 1'b0, ~a, 8'hff};
    @(posedge clk_in);
    v = rsp_in.valid;
    d = rsp_in.data;
  endtask
endmodule

// *** sim/reader_fifo_buffer_control_tb.sv ***
// self-checking bench for the reader byte buffer
`timescale 1ns/10ps
`include "reader_fifo_params.svh"
module reader_fifo_buffer_control_tb
  import reader_fifo_pkg::*;
;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic pop_in = 1'b0;
  host_req_s req;
  host_rsp_s rsp;
  logic [6:0] addr;
  logic wrdy, rvld, dsel, hi, lo, v;
  logic [7:0] rdat, d;
  logic [9:0] cnt;
  int failures = 0;
  int checks = 0;
  int ds = 0, wml = 0, wmh = 0;
  byte unsigned q[$];
  always #5 clk_in = ~clk_in;
  host_model host_model_inst (.clk_in(clk_in), .req_out(req), .rsp_in(rsp));
  reader_fifo_buffer_control reader_fifo_buffer_control_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .host_req_in(req), .host_rsp_out(rsp), .host_addr_out(addr),
    .core_wvalid_in(wv), .core_wdata_in(wd), .core_wready_out(wrdy), .core_pop_in(pop_in),
    .core_rvalid_out(rvld), .core_rdata_out(rdat), .depth_select_out(dsel),
    .high_alert_flag_out(hi), .low_alert_flag_out(lo), .fill_count_out(cnt));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string n);
    host_model_inst.rd(a, v, d);
    chk(n, {8'h01, e}, {7'h00, v, d});
  endtask
  function automatic logic [7:0] ectl();
    int dep = ds ? 255 : 512;
    int wm = ds ? wml : wmh * 256 + wml;
    int n = q.size();
    ectl = {ds[0], 1'((dep - n) <= wm), 1'(n <= wm), 2'b00, wmh[0], 2'(n >> 8)};
  endfunction
  task automatic status();
    logic [7:0] e;
    e = ectl();
    rdc(`REG_CTRL, e, "ctrl");
    rdc(`REG_CNT, 8'(q.size()), "count");
    chk("pins", {14'h0000, e[6:5]}, {14'h0000, hi, lo});
    chk("fill", 16'(q.size()), {6'h00, cnt});
    chk("depth", 16'(ds), {15'h0000, dsel});
    chk("ready", 16'h0001, {15'h0000, wrdy});
  endtask
  task automatic push(input logic [7:0] b);
    host_model_inst.wr(`REG_DATA, b);
    // a full buffer drops the byte, so the model keeps it out too
    if (q.size() < (ds ? 255 : 512)) q.push_back(b);
  endtask
  task automatic pop();
    rdc(`REG_DATA, q.size() ? q.pop_front() : 8'h00, "data");
  endtask
  task automatic flush(input logic [7:0] c);
    host_model_inst.wr(`REG_CTRL, c | 8'h10);
    q.delete();
    ds = c[7];
    wmh = c[2];
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    report_and_stop();
  end
  initial begin
    void'($urandom(72));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    status();
    host_model_inst.wr(`REG_WM, 8'h05);
    wml = 5;
    rdc(`REG_WM, 8'h05, "wm");
    repeat (10) push(8'($urandom));
    chk("ptr", 16'(`REG_DATA), {9'h000, addr});
    repeat (3) pop();
    host_model_inst.cont(1'b1, 8'h3c, v, d);
    q.push_back(8'h3c);
    chk("wrsp", 16'h0000, {7'h00, v, d});
    host_model_inst.cont(1'b0, 8'h00, v, d);
    chk("burst", {8'h01, q.pop_front()}, {7'h00, v, d});
    chk("ptr", 16'(`REG_DATA), {9'h000, addr});
    host_model_inst.wr(`REG_CNT, 8'hff);
    status();
    rdc(7'h10, 8'h00, "unmapped");
    chk("ptr", 16'h0011, {9'h000, addr});
    flush(8'h80);
    host_model_inst.wr(`REG_WM, 8'h06);
    wml = 6;
    repeat (256) push(8'($urandom));
    status();
    repeat (256) pop();
    flush(8'h04);
    repeat (300) push(8'($urandom));
    status();
    flush(8'h00);
    wv <= 1'b1;
    repeat (3) begin
      wd <= 8'($urandom);
      do @(posedge clk_in); while (wrdy !== 1'b1);
      q.push_back(wd);
    end
    wv <= 1'b0;
    for (int k = 0; k < 20 && cnt !== 10'h003; k++) @(posedge clk_in);
    chk("drain", 16'h0003, {6'h00, cnt});
    repeat (2) begin
      pop_in <= 1'b1;
      @(posedge clk_in);
      pop_in <= 1'b0;
      @(posedge clk_in);
      chk("core", {7'h00, 1'b1, q.pop_front()}, {7'h00, rvld, rdat});
    end
    pop();
    status();
    report_and_stop();
  end
endmodule
bind reader_fifo_buffer_control reader_fifo_checker chk_inst (.clk_in(clk_in),
  .resetn_in(resetn_in), .host_req_in(host_req_in), .host_rsp_out(host_rsp_out),
  .host_addr_out(host_addr_out), .core_pop_in(core_pop_in), .core_rvalid_out(core_rvalid_out),
  .depth_select_out(depth_select_out), .high_alert_flag_out(high_alert_flag_out),
  .low_alert_flag_out(low_alert_flag_out), .fill_count_out(fill_count_out));
